// ===== hw/rss_core.sv
/*
  Top of the rotate, subtract and skip datapath: accumulator, flags, memory write-back, skip.
  Assumes mem_rdata is the operand at the addressed location while op_valid is high, and
  that the sequencer inserts the dummy cycle when skip_req is seen.
*/
// Operation
// RQ1: Rotate right to accumulator: acc[6:0] from operand[7:1], acc[7] from old carry.
// RQ2: Rotate right to accumulator writes carry with operand bit 0.
// RQ3: Rotate right to accumulator writes only the accumulator and carry, never memory.
// RQ4: Subtract to accumulator: acc minus operand minus inverted carry into accumulator.
// RQ5: Subtract to memory: same difference written back to the addressed location.
// RQ6: Both subtracts: carry is not-borrow; overflow, zero and half carry also updated.
// RQ7: Decrement and skip: operand minus one written back; skip when result is zero.
// RQ8: On a skip the sequencer inserts a dummy cycle; two cycles total.
// RQ9: Nonzero decrement result: no skip, execution continues normally.
// RQ10: Rotate and decrement keep Z, OV, AC; decrement also keeps carry.
module rss_core
  import rss_pkg::*;
(
  input  logic              clk,        // Core clock
  input  logic              sys_rst,    // Asynchronous reset, active high
  input  logic              op_valid,   // Operation presented this cycle
  input  rss_pkg::rss_op_t  op_code,    // Operation select
  input  logic [7:0]        mem_rdata,  // Operand from data memory
  output logic [7:0]        acc_r,      // Accumulator
  output logic              carry_r,    // Carry flag
  output logic              zero_r,     // Zero flag
  output logic              ovf_r,      // Overflow flag
  output logic              half_r,     // Auxiliary carry flag
  output logic              mem_we_r,   // Memory write strobe, one cycle
  output logic [7:0]        mem_wdata_r,// Memory write data
  output logic              skip_req_r  // Skip next instruction, one cycle
);
  rss_alu_if alu_bus ();

  // Rotate right through carry into the accumulator
  function automatic logic f_is_rot(
    input logic    valid,  // Operation strobe
    input rss_op_t code    // Operation select
  );
    return valid && (code == RSS_OP_ROT_ACC);
  endfunction : f_is_rot

  // Subtract with borrow, result to the accumulator
  function automatic logic f_is_sub_acc(
    input logic    valid,  // Operation strobe
    input rss_op_t code    // Operation select
  );
    return valid && (code == RSS_OP_SUB_ACC);
  endfunction : f_is_sub_acc

  // Subtract with borrow, result back to memory
  function automatic logic f_is_sub_mem(
    input logic    valid,  // Operation strobe
    input rss_op_t code    // Operation select
  );
    return valid && (code == RSS_OP_SUB_MEM);
  endfunction : f_is_sub_mem

  // Either subtract form; both share the flag update
  function automatic logic f_is_sub(
    input logic    valid,  // Operation strobe
    input rss_op_t code    // Operation select
  );
    return f_is_sub_acc(valid, code) || f_is_sub_mem(valid, code);
  endfunction : f_is_sub

  // Decrement and skip if zero
  function automatic logic f_is_dec(
    input logic    valid,  // Operation strobe
    input rss_op_t code    // Operation select
  );
    return valid && (code == RSS_OP_DEC_SKP);
  endfunction : f_is_dec

  // Operations that write data memory; rotate never does
  function automatic logic f_writes_mem(
    input logic    valid,  // Operation strobe
    input rss_op_t code    // Operation select
  );
    return f_is_sub_mem(valid, code) || f_is_dec(valid, code);
  endfunction : f_writes_mem

  // Old carry enters at the top, operand shifts down
  function automatic logic [7:0] f_rotate_right(
    input logic       cin,      // Carry before the operation
    input logic [7:0] operand   // Memory operand
  );
    return {cin, operand[7:1]};
  endfunction : f_rotate_right

  // Bit that falls out of the bottom becomes the new carry
  function automatic logic f_rot_carry(
    input logic [7:0] operand   // Memory operand
  );
    return operand[0];
  endfunction : f_rot_carry

  // Wraps from 0 to all ones, as an 8-bit counter does
  function automatic logic [7:0] f_decrement(
    input logic [7:0] operand   // Memory operand
  );
    return operand - DEC_ONE;
  endfunction : f_decrement

  // Zero test shared by the zero flag and the skip decision
  function automatic logic f_is_zero(
    input logic [7:0] value     // Value under test
  );
    return value == 8'h00;
  endfunction : f_is_zero

  logic [7:0] dec_val;
  logic       is_rot;
  logic       is_sba;
  logic       is_sbm;
  logic       is_sub;
  logic       is_dec;
  logic       wr_mem;
  logic       dec_zero;

  assign alu_bus.acc = acc_r;
  assign alu_bus.mem = mem_rdata;
  assign alu_bus.cin = carry_r;

  rss_sub_alu u_alu (
    .alu (alu_bus.alu)
  );

  assign dec_val  = f_decrement(mem_rdata);
  assign is_rot   = f_is_rot(op_valid, op_code);
  assign is_sba   = f_is_sub_acc(op_valid, op_code);
  assign is_sbm   = f_is_sub_mem(op_valid, op_code);
  assign is_sub   = f_is_sub(op_valid, op_code);
  assign is_dec   = f_is_dec(op_valid, op_code);
  assign wr_mem   = f_writes_mem(op_valid, op_code);
  assign dec_zero = f_is_zero(dec_val);

  // Accumulator
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_r <= ACC_RST;
    end else if (is_rot) begin
      acc_r <= f_rotate_right(carry_r, mem_rdata); // RQ1
    end else if (is_sba) begin
      acc_r <= alu_bus.diff; // RQ4
    end
  end

  // Carry; decrement leaves it alone
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      carry_r <= FLAG_RST;
    end else if (is_rot) begin
      carry_r <= f_rot_carry(mem_rdata); // RQ2
    end else if (is_sub) begin
      carry_r <= alu_bus.c_out; // RQ6
    end
  end

  // Zero: only subtracts touch it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      zero_r <= FLAG_RST;
    end else if (is_sub) begin
      zero_r <= f_is_zero(alu_bus.diff); // RQ6
    end // RQ10
  end

  // Overflow: only subtracts touch it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovf_r <= FLAG_RST;
    end else if (is_sub) begin
      ovf_r <= alu_bus.ov_out; // RQ6
    end // RQ10
  end

  // Half carry: only subtracts touch it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      half_r <= FLAG_RST;
    end else if (is_sub) begin
      half_r <= alu_bus.ac_out; // RQ6
    end // RQ10
  end

  // Memory write strobe, one cycle per writing operation
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_we_r <= 1'b0;
    end else begin
      mem_we_r <= wr_mem; // RQ3 RQ5 RQ7
    end
  end

  // Memory write data, held until the next write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_wdata_r <= 8'h00;
    end else if (is_sbm) begin
      mem_wdata_r <= alu_bus.diff; // RQ5
    end else if (is_dec) begin
      mem_wdata_r <= dec_val; // RQ7
    end
  end

  // Skip request to the sequencer; it must turn the next slot into a dummy
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      skip_req_r <= 1'b0;
    end else begin
      skip_req_r <= is_dec && dec_zero; // RQ7 RQ8 RQ9
    end
  end
endmodule : rss_core

// ===== hw/rss_pkg.sv
/*
  Package for the rotate, subtract and skip datapath: opcodes, widths, reset values.
  Assumes a single core clock and an instruction sequencer that presents one op per cycle.
*/
package rss_pkg;
  localparam int unsigned DATA_W = 8;

  typedef enum logic [2:0] {
    RSS_OP_NONE    = 3'b000,
    RSS_OP_ROT_ACC = 3'b001,
    RSS_OP_SUB_ACC = 3'b010,
    RSS_OP_SUB_MEM = 3'b011,
    RSS_OP_DEC_SKP = 3'b100
  } rss_op_t;

  localparam logic [7:0] ACC_RST  = 8'h00;
  localparam logic       FLAG_RST = 1'b0;
  localparam logic [7:0] DEC_ONE  = 8'h01;
  localparam int unsigned SIGN_BIT = 7;
  localparam int unsigned NIB_W    = 4;
endpackage : rss_pkg

// ===== hw/rss_alu_if.sv
/*
  Interface carrying operands and results between the top and its arithmetic unit.
  Assumes both ends run on the same clock; the signals are purely combinational.
*/
interface rss_alu_if;
  logic [7:0] acc;
  logic [7:0] mem;
  logic       cin;
  logic [7:0] diff;
  logic       c_out;
  logic       ov_out;
  logic       ac_out;

  modport top (output acc, output mem, output cin, input diff, input c_out,
               input ov_out, input ac_out);
  modport alu (input acc, input mem, input cin, output diff, output c_out,
               output ov_out, output ac_out);
endinterface : rss_alu_if

// ===== hw/rss_sub_alu.sv
/*
  Subtract-with-borrow unit: acc - mem - not carry, with carry, overflow and half carry.
  Assumes the caller registers the results.
*/
module rss_sub_alu
  import rss_pkg::*;
(
  rss_alu_if.alu alu  // Operands and results
);
  logic [8:0] full;
  logic [4:0] low;

  always_comb begin
    full = {1'b0, alu.acc} - {1'b0, alu.mem} - {8'h00, ~alu.cin};
    low  = {1'b0, alu.acc[NIB_W-1:0]} - {1'b0, alu.mem[NIB_W-1:0]} - {4'h0, ~alu.cin};
    alu.diff   = full[7:0];
    alu.c_out  = ~full[8];
    alu.ac_out = ~low[4];
    alu.ov_out = (alu.acc[SIGN_BIT] ^ alu.mem[SIGN_BIT])
               & (alu.acc[SIGN_BIT] ^ full[SIGN_BIT]);
  end
endmodule : rss_sub_alu

// ===== test/rss_mem_model.sv
/* Data memory partner: four bytes, preload port, write lands one cycle late.
   Assumes the core clock only. */
module rss_mem_model (
  input  logic       clk,   // Core clock
  input  logic [1:0] addr,  // Addressed location
  input  logic       ld,    // Preload strobe
  input  logic [7:0] ldv,   // Preload value
  input  logic       we,    // Core write strobe
  input  logic [7:0] wd,    // Core write data
  output logic [7:0] rd     // Operand
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] m [4];
  logic [1:0] a_q;
  assign rd = m[addr];
  always_ff @(posedge clk) begin
    a_q <= addr;
    if (ld) m[addr] <= ldv;
    else if (we) m[a_q] <= wd;
  end
endmodule : rss_mem_model

// ===== test/rss_core_chk.sv
/* Port checker for rss_core. Assumes the bind below. */
module rss_core_chk
  import rss_pkg::*;
(
  input logic             clk, sys_rst, op_valid,  // Clock, reset, strobe
  input rss_pkg::rss_op_t op_code,                 // Operation
  input logic [7:0]       mem_rdata, acc_r, mem_wdata_r, // Data
  input logic             carry_r, zero_r, ovf_r, half_r, mem_we_r, skip_req_r // Flags
);
  logic [8:0] d;
  logic       rot, sba, sbm, dec;
  assign d = {1'b0, acc_r} - {1'b0, mem_rdata} - {8'h00, !carry_r};
  assign rot = op_valid && op_code == RSS_OP_ROT_ACC;
  assign sba = op_valid && op_code == RSS_OP_SUB_ACC;
  assign sbm = op_valid && op_code == RSS_OP_SUB_MEM;
  assign dec = op_valid && op_code == RSS_OP_DEC_SKP;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_rot_result: assert property (rot |=> !mem_we_r && carry_r == $past(mem_rdata[0])
    && acc_r == {$past(carry_r), $past(mem_rdata[7:1])}) else $error("rotate result");
  a_sub_acc: assert property (sba |=> acc_r == $past(d[7:0]))
    else $error("sub to acc");
  a_sub_mem: assert property (sbm |=> mem_we_r && mem_wdata_r == $past(d[7:0])
    && acc_r == $past(acc_r)) else $error("sub to mem");
  a_sub_carry: assert property ((sba || sbm) |=> carry_r == !$past(d[8])
    && zero_r == ($past(d[7:0]) == 8'h00)) else $error("sub flags");
  a_dec_write: assert property (dec |=> mem_we_r && $stable(carry_r)
    && mem_wdata_r == $past(mem_rdata) - 8'h01) else $error("dec write");
  a_dec_skip: assert property (dec |=> skip_req_r == ($past(mem_rdata) == 8'h01))
    else $error("dec skip");
  a_keep_flags: assert property ((rot || dec) |=> $stable({zero_r, ovf_r, half_r}))
    else $error("flags moved");
  a_skip_pulse: assert property (skip_req_r |=> !skip_req_r) else $error("skip held");
endmodule : rss_core_chk
bind rss_core rss_core_chk rss_core_chk_inst (.clk, .sys_rst, .op_valid, .op_code, .mem_rdata,
  .acc_r, .mem_wdata_r, .carry_r, .zero_r, .ovf_r, .half_r, .mem_we_r, .skip_req_r);

// ===== test/tb.sv
/* Self-checking bench for rss_core; the bench acts as sequencer.
   Assumes rss_pkg and the memory model. */
module tb;
  import rss_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, sys_rst, op_valid, ld, carry_r, zero_r, ovf_r, half_r, mem_we_r;
  logic       skip_req_r, e_c, e_z, e_v, e_h;
  logic [7:0] mem_rdata, acc_r, mem_wdata_r, ldv, e_acc, e_wd, mir [4];
  logic [1:0] addr;
  rss_op_t    op_code;
  logic [21:0] q [$];
  wire  [21:0] seen = {acc_r, carry_r, zero_r, ovf_r, half_r, mem_we_r, mem_wdata_r, skip_req_r};
  int         fail_count = 0, n_compared = 0;
  rss_core rss_core_inst (.clk, .sys_rst, .op_valid, .op_code, .mem_rdata, .acc_r, .carry_r,
    .zero_r, .ovf_r, .half_r, .mem_we_r, .mem_wdata_r, .skip_req_r);
  rss_mem_model rss_mem_model_inst (.clk, .addr, .ld, .ldv, .we(mem_we_r), .wd(mem_wdata_r),
    .rd(mem_rdata));
  task automatic chk(input logic [21:0] e, input logic [21:0] s);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch outputs exp %h seen %h", e, s);
    end
  endtask : chk
  task automatic step(input logic v, input rss_op_t o, input logic [1:0] ad);
    logic [8:0] d;
    logic [4:0] lo;
    logic       ov;
    logic       we;
    logic       sk;
    @(negedge clk);
    if (skip_req_r === 1'b1) v = 1'b0;
    {ld, op_valid, op_code, addr, we, sk} = {1'b0, v, o, ad, 2'b00};
    d = {1'b0, e_acc} - {1'b0, mir[ad]} - {8'h00, !e_c};
    lo = {1'b0, e_acc[3:0]} - {1'b0, mir[ad][3:0]} - {4'h0, !e_c};
    ov = (e_acc[7] ^ mir[ad][7]) & (e_acc[7] ^ d[7]);
    if (v) case (o)
      RSS_OP_ROT_ACC: {e_acc, e_c} = {e_c, mir[ad]};
      RSS_OP_SUB_ACC: {e_c, e_z, e_v, e_h, e_acc} = {!d[8], d[7:0] == 8'h00, ov, !lo[4], d[7:0]};
      RSS_OP_SUB_MEM: {e_c, e_z, e_v, e_h, we, e_wd} = {!d[8], d[7:0] == 8'h00, ov, !lo[4],
                                                        1'b1, d[7:0]};
      RSS_OP_DEC_SKP: {we, e_wd, sk} = {1'b1, mir[ad] - 8'h01, mir[ad] == 8'h01};
      default: ;
    endcase
    if (we) mir[ad] = e_wd;
    q.push_back({e_acc, e_c, e_z, e_v, e_h, we, e_wd, sk});
  endtask : step
  task automatic stop_test;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    #1;
    if (q.size() > 0) chk(q.pop_front(), seen);
  end
  initial begin
    {sys_rst, op_valid, op_code, ld, addr, ldv, e_acc, e_c, e_z, e_v, e_h, e_wd} = {1'b1, 35'h0};
    void'($urandom(87782));
    repeat (3) @(posedge clk);
    @(negedge clk) sys_rst = 0;
    for (int t = 0; t < 3; t++) begin
      for (int i = 0; i < 4; i++) begin
        @(negedge clk);
        {op_valid, ld, addr, ldv} = {2'b01, 2'(i), i ? 8'($urandom) : 8'h01};
        mir[i] = ldv;
      end
      step(1'b1, RSS_OP_DEC_SKP, 2'h0);
      for (int j = 1; j < 24; j++) step(1'($urandom), rss_op_t'($urandom_range(0, 7)), 2'(j));
      $display("test %0d done", t);
    end
    repeat (2) @(negedge clk);
    stop_test();
  end
  initial begin
    #20000;
    fail_count++;
    stop_test();
  end
endmodule : tb
